// File: hdl/aomc_top.sv
// analog output selection control top: number, address, channel enables
`timescale 1ns/1ps
module aomc_top #(
  parameter int NUM_W  = aomc_pkg::NUM_W,
  parameter int ADDR_W = aomc_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // processor side
  input  wire logic              multiplexed_analog_out_instr,
  input  wire logic [NUM_W-1:0]  num_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  // converter and channel side
  output logic      [NUM_W-1:0]  dac_value,
  output logic      [ADDR_W-1:0] addr_reg,
  output logic      [7:0]        row_sel,
  output logic      [7:0]        col_sel,
  output logic      [63:0]       chan_en,
  output logic                   dwell_met
);
  typedef enum logic [0:0] {
    AOMC_IDLE  = 1'b0,
    AOMC_DWELL = 1'b1
  } aomc_state_t;

  localparam logic [15:0] DWELL_MAX = 16'(aomc_pkg::DWELL_CYC);

  // parameter sanity, refused while elaborating: the selection link and the
  // reset constants are cut to the package widths, so other widths would
  // silently pad or drop address and number bits
  if (NUM_W != aomc_pkg::NUM_W || ADDR_W != aomc_pkg::ADDR_W) begin : g_bad_width
    $error("unsupported width parameters");
  end

  aomc_sel_if sel ();

  logic [NUM_W-1:0]  num_reg;
  logic [NUM_W-1:0]  next_num_reg;
  logic [ADDR_W-1:0] next_addr_reg;
  aomc_state_t       state;
  aomc_state_t       next_state;
  logic [15:0]       dwell_cnt;
  logic [15:0]       next_dwell_cnt;

  // [RULE1] [RULE2] [RULE3] registers load on the instruction
  // both registers take their inputs on the same edge, so the converter
  // value and the channel that receives it never get out of step
  always_comb begin
    next_num_reg  = num_reg;
    next_addr_reg = addr_reg;
    if (multiplexed_analog_out_instr) begin
      next_num_reg  = num_in;
      next_addr_reg = addr_in;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      num_reg  <= aomc_pkg::NUM_RESET;
      addr_reg <= aomc_pkg::ADDR_RESET;
    end else begin
      num_reg  <= next_num_reg;
      addr_reg <= next_addr_reg;
    end
  end

  // converter follows the number register directly
  // no extra stage: the converter settles well inside the dwell anyway
  assign dac_value = num_reg;

  // [RULE4] same instruction loads the selection banks
  // banks decode the raw input rather than addr_reg, so they switch on the
  // same edge as the number register and not one cycle later
  assign sel.load = multiplexed_analog_out_instr;
  assign sel.addr = addr_in;

  aomc_coord_bank u_bank (
    .clock (clock),
    .rst_b (rst_b),
    .sel   (sel)
  );

  assign row_sel = sel.row_sel;
  assign col_sel = sel.col_sel;

  // [RULE9] [RULE10] channel enabled only at row and column coincidence
  // one gate level behind two registered banks; both banks move on one edge,
  // so no channel outside the old or new coordinates ever opens
  genvar r, c;
  generate
    for (r = 0; r < aomc_pkg::COORD_N; r++) begin : g_row
      for (c = 0; c < aomc_pkg::COORD_N; c++) begin : g_col
        assign chan_en[r*aomc_pkg::COORD_N + c] = row_sel[r] & col_sel[c];
      end
    end
  endgenerate

  // [RULE7] dwell timer; software reads dwell_met before the next update
  // counts 1 up to DWELL_MAX after each strobe; a strobe inside the dwell
  // restarts it, since the newly selected channel needs its own settle time
  always_comb begin
    next_state     = state;
    next_dwell_cnt = dwell_cnt;
    unique case (state)
      AOMC_IDLE: begin
        if (multiplexed_analog_out_instr) begin
          next_state     = AOMC_DWELL;
          next_dwell_cnt = 16'h0001;
        end
      end
      AOMC_DWELL: begin
        // fresh strobe restarts the count
        if (multiplexed_analog_out_instr) begin
          next_dwell_cnt = 16'h0001;
        // full dwell served
        end else if (dwell_cnt == DWELL_MAX) begin
          next_state = AOMC_IDLE;
        end else begin
          next_dwell_cnt = dwell_cnt + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state     <= AOMC_IDLE;
      dwell_cnt <= 16'h0000;
    end else begin
      state     <= next_state;
      dwell_cnt <= next_dwell_cnt;
    end
  end

  // high once the selected channel has settled, or nothing pending
  // a level, not a pulse: software may poll it at any time
  assign dwell_met = (state == AOMC_IDLE);

  // checker helper: length of the current low stretch of dwell_met,
  // restarted by every strobe; kept apart from the dwell timer so that
  // a broken timer cannot vouch for itself
  logic [15:0] low_run;
  logic [15:0] next_low_run;

  // stretch counter, next value
  always_comb begin
    next_low_run = low_run;
    if (multiplexed_analog_out_instr) begin
      next_low_run = 16'h0000;
    end else if (!dwell_met) begin
      next_low_run = low_run + 16'h0001;
    end
  end

  // stretch counter register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_run <= 16'h0000;
    end else begin
      low_run <= next_low_run;
    end
  end

  // checks watch inputs, outputs and registers only; all are off while reset is low
  // so that an asynchronous clear never counts as a drifting register

  // [RULE3] converter takes new value
  chk_dac_load: assert property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr |=> dac_value == $past(num_in))  // [RULE3]
    else $error("converter not loaded");
  // [RULE4] addressed channel enabled
  chk_chan_select: assert property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr |=> chan_en[$past(addr_in[5:0])])  // [RULE4]
    else $error("addressed channel not enabled");
  // [RULE2] address register captured
  chk_addr_load: assert property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr |=> addr_reg == $past(addr_in))  // [RULE2]
    else $error("address not captured");
  // [RULE9] single channel at most
  chk_chan_onehot: assert property (@(posedge clock) disable iff (!rst_b)
    $onehot0(chan_en))  // [RULE9]
    else $error("more than one channel enabled");
  // [RULE10] selection holds without instruction
  chk_sel_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !multiplexed_analog_out_instr |=> $stable(chan_en) && $stable(dac_value))  // [RULE10]
    else $error("selection changed without instruction");
  // [RULE1] number register holds
  chk_num_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !multiplexed_analog_out_instr [*2] |-> $stable(num_reg))  // [RULE1]
    else $error("number register drifted");
  // [RULE8] channel index matches banks
  chk_bank_map: assert property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr |=> row_sel[$past(addr_in[5:3])] && col_sel[$past(addr_in[2:0])])  // [RULE8]
    else $error("bank coordinates wrong");
  // [RULE7] dwell flag low right after an update
  chk_dwell_low: assert property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr |=> !dwell_met [*8])  // [RULE7]
    else $error("dwell flag rose too early");
  // [RULE2] address register holds between strobes
  chk_addr_hold: assert property (@(posedge clock) disable iff (!rst_b)
    !multiplexed_analog_out_instr |=> $stable(addr_reg))  // [RULE2]
    else $error("address register changed without instruction");
  // [RULE7] low stretch lasts the whole dwell
  chk_dwell_span: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(dwell_met) |-> low_run == DWELL_MAX)  // [RULE7]
    else $error("dwell stretch has the wrong length");
  // [RULE7] dwell count stays in range
  chk_dwell_range: assert property (@(posedge clock) disable iff (!rst_b)
    state == AOMC_DWELL |-> dwell_cnt != 16'h0000 && dwell_cnt <= DWELL_MAX)  // [RULE7]
    else $error("dwell count out of range");

  // main scenarios: single update, back to back, restart, full dwell, far corner

  cov_update: cover property (@(posedge clock) disable iff (!rst_b) multiplexed_analog_out_instr);
  cov_back_to_back: cover property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr ##1 multiplexed_analog_out_instr);
  cov_dwell_done: cover property (@(posedge clock) disable iff (!rst_b)
    state == AOMC_DWELL ##1 state == AOMC_IDLE);
  cov_dwell_restart: cover property (@(posedge clock) disable iff (!rst_b)
    !dwell_met && multiplexed_analog_out_instr);
  cov_last_chan: cover property (@(posedge clock) disable iff (!rst_b)
    multiplexed_analog_out_instr ##1 chan_en[aomc_pkg::CHAN_N-1]);
endmodule

// File: hdl/aomc_pkg.sv
// constants for the analog output selection control
// How it works
// [RULE1] a 12-bit number register holds the value driving the shared converter
// [RULE2] a 16-bit address register picks one of 64 output channels
// [RULE3] the output instruction loads the converter from the number register
// [RULE4] the same instruction enables the channel named by the address register
// [RULE5] software alone decides order and timing of channel updates
// [RULE6] software refreshes each used channel at least every 50 ms
// [RULE7] software keeps each channel selected at least 100 us per update
// [RULE8] channels form an 8 by 8 array with row and column flip-flop banks
// [RULE9] a channel is selected only when its row and column flip-flops are set
// [RULE10] unselected channels stay isolated and hold their last value
// [RULE11] at most one row and one column set; others cleared on new address
// [RULE12] address bits 2:0 give column, bits 5:3 give row
package aomc_pkg;
  localparam int          NUM_W       = 12;
  localparam int          ADDR_W      = 16;
  localparam int          COORD_W     = 3;
  localparam int          COORD_N     = 8;
  localparam int          CHAN_N      = 64;
  localparam int          COL_LSB     = 0;
  localparam int          ROW_LSB     = 3;
  localparam logic [11:0] NUM_RESET   = 12'h000;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [7:0]  SEL_NONE    = 8'h00;
  localparam int          CLK_NS      = 50;
  localparam int          DWELL_US    = 100;
  localparam int          REFRESH_MS  = 50;
  // least time, rounded up to whole cycles
  localparam int          DWELL_CYC   = (DWELL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int          REFRESH_CYC = (REFRESH_MS * 1000000) / CLK_NS;
endpackage

// File: hdl/aomc_sel_if.sv
// selection bank signals between the control and the coordinate decoder
`timescale 1ns/1ps
interface aomc_sel_if;
  logic                            load;
  logic [aomc_pkg::ADDR_W-1:0]     addr;
  logic [aomc_pkg::COORD_N-1:0]    row_sel;
  logic [aomc_pkg::COORD_N-1:0]    col_sel;
  modport ctl (output load, output addr, input row_sel, input col_sel);
  modport bank (input load, input addr, output row_sel, output col_sel);
endinterface

// File: hdl/aomc_coord_bank.sv
// row and column selection flip-flop banks with one-hot decode
`timescale 1ns/1ps
module aomc_coord_bank (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // selection link
  aomc_sel_if.bank  sel
);
  logic [aomc_pkg::COORD_N-1:0] row_sel;
  logic [aomc_pkg::COORD_N-1:0] col_sel;
  logic [aomc_pkg::COORD_N-1:0] next_row_sel;
  logic [aomc_pkg::COORD_N-1:0] next_col_sel;

  // one-hot decode of a coordinate, used for both banks
  function automatic logic [aomc_pkg::COORD_N-1:0] one_hot(input logic [aomc_pkg::COORD_W-1:0] idx);
    logic [aomc_pkg::COORD_N-1:0] v;
    v = aomc_pkg::SEL_NONE;
    v[idx] = 1'b1;
    return v;
  endfunction

  // [RULE12] address field split
  // [RULE11] whole bank rewritten so old bits clear
  always_comb begin
    next_row_sel = row_sel;
    next_col_sel = col_sel;
    if (sel.load) begin
      next_row_sel = one_hot(sel.addr[aomc_pkg::ROW_LSB +: aomc_pkg::COORD_W]);
      next_col_sel = one_hot(sel.addr[aomc_pkg::COL_LSB +: aomc_pkg::COORD_W]);
    end
  end

  // [RULE8] eight flip-flops per coordinate
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      row_sel <= aomc_pkg::SEL_NONE;
      col_sel <= aomc_pkg::SEL_NONE;
    end else begin
      row_sel <= next_row_sel;
      col_sel <= next_col_sel;
    end
  end

  assign sel.row_sel = row_sel;
  assign sel.col_sel = col_sel;

  // [RULE11] one-hot or empty banks
  chk_bank_onehot: assert property (@(posedge clock) disable iff (!rst_b)
    $onehot0(row_sel) && $onehot0(col_sel) && ($onehot(row_sel) == $onehot(col_sel)))  // [RULE11]
    else $error("selection banks not one-hot");
endmodule

// File: tb/aomc_load_model.sv
// sample-and-hold loads on the 64 output channels
`timescale 1ns/1ps
module aomc_load_model (
  // clock
  input  wire logic        clock,
  // converter and channel enables
  input  wire logic [11:0] dac_value,
  input  wire logic [63:0] chan_en,
  // probe
  input  wire logic [5:0]  pick,
  output logic      [11:0] held,
  output logic             stale
);
  logic [11:0] store [64];
  logic        used  [64] = '{default: 1'b0};
  int          age   [64] = '{default: 0};
  logic        late       = 1'b0;
  // each written channel ages until it is rewritten
  always @(posedge clock) begin
    for (int i = 0; i < 64; i++) begin
      if (chan_en[i] === 1'b1) begin
        store[i] <= dac_value;
        used[i]  <= 1'b1;
        age[i]   <= 0;
      end else if (used[i]) begin
        age[i] <= age[i] + 1;
        if (age[i] >= aomc_pkg::REFRESH_CYC) begin
          late <= 1'b1;
        end
      end
    end
  end
  assign held  = store[pick];
  assign stale = late;
endmodule

// File: tb/analog_output_mux_control_bench.sv
// self-checking bench for the analog output selection control
`timescale 1ns/1ps
module analog_output_mux_control_bench;
  logic        clock   = 1'b0;
  logic        rst_b   = 1'b0;
  logic        instr   = 1'b0;
  logic [11:0] num_in  = 12'h000;
  logic [15:0] addr_in = 16'h0000;
  logic [5:0]  pick    = 6'h00;
  logic [11:0] dac_value;
  logic [11:0] held;
  logic [15:0] addr_reg;
  logic [7:0]  row_sel;
  logic [7:0]  col_sel;
  logic [63:0] chan_en;
  logic        dwell_met;
  logic        stale;
  int          num_errors = 0;
  int          compares   = 0;
  logic [15:0] adrs [3] = '{16'h0000, 16'hFFFF, 16'h002A};
  logic [11:0] nums [3] = '{12'hFFF, 12'h001, 12'h5A3};
  always #25 clock = ~clock;
  aomc_top u_aomc_top (.clock(clock), .rst_b(rst_b), .multiplexed_analog_out_instr(instr), .num_in(num_in),
    .addr_in(addr_in), .dac_value(dac_value), .addr_reg(addr_reg), .row_sel(row_sel), .col_sel(col_sel),
    .chan_en(chan_en), .dwell_met(dwell_met));
  aomc_load_model u_aomc_load_model (.clock(clock), .dac_value(dac_value), .chan_en(chan_en), .pick(pick),
    .held(held), .stale(stale));
  task test_done;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // one update strobe, outputs settled on return
  task upd(input logic [11:0] n, input logic [15:0] a);
    @(posedge clock);
    instr   <= 1'b1;
    num_in  <= n;
    addr_in <= a;
    @(posedge clock);
    instr <= 1'b0;
    #1;
  endtask
  task wait_dwell(output int c);
    c = 0;
    while (dwell_met !== 1'b1) begin
      @(posedge clock);
      #1;
      c++;
      if (c > 2100) begin
        chk(64'h0, 64'h1);
        test_done();
      end
    end
  endtask
  task t_reset;
    chk(dac_value, 12'h000);
    chk(addr_reg, 16'h0000);
    chk({row_sel, col_sel}, 16'h0000);
    chk(chan_en, 64'h0);
    chk(dwell_met, 1'b1);
  endtask
  task t_update;
    int c;
    for (int i = 0; i < 3; i++) begin
      upd(nums[i], adrs[i]);
      chk(dac_value, nums[i]);
      chk(addr_reg, adrs[i]);
      chk(row_sel, 8'h01 << adrs[i][5:3]);
      chk(col_sel, 8'h01 << adrs[i][2:0]);
      chk(chan_en, 64'h1 << adrs[i][5:0]);
      chk(dwell_met, 1'b0);
      wait_dwell(c);
      chk(c, aomc_pkg::DWELL_CYC);
    end
    // refresh comes far inside the interval
    pick = 6'h00;
    #1;
    chk(held, nums[0]);
    pick = 6'h3F;
    #1;
    chk(held, nums[1]);
    chk(stale, 1'b0);
  endtask
  // held strobe: two updates back to back, the second restarts the dwell
  task t_b2b;
    int c;
    @(posedge clock);
    instr   <= 1'b1;
    num_in  <= 12'h123;
    addr_in <= 16'h0009;
    @(posedge clock);
    num_in  <= 12'h456;
    addr_in <= 16'h0036;
    #1;
    chk(dac_value, 12'h123);
    chk({row_sel, col_sel}, 16'h0202);
    @(posedge clock);
    instr <= 1'b0;
    #1;
    chk(dac_value, 12'h456);
    chk({row_sel, col_sel}, 16'h4040);
    chk(chan_en, 64'h1 << 6'h36);
    wait_dwell(c);
    chk(c, aomc_pkg::DWELL_CYC);
  endtask
  // reset in mid-run during a dwell; outputs clear, loads keep their charge
  task t_mid_reset;
    upd(12'hABC, 16'h0012);
    @(posedge clock);
    rst_b <= 1'b0;
    #1;
    t_reset();
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    pick = 6'h12;
    #1;
    chk(held, 12'hABC);
    upd(12'h7E1, 16'h8024);
    chk(dac_value, 12'h7E1);
    chk(addr_reg, 16'h8024);
    chk(chan_en, 64'h1 << 6'h24);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1;
    t_reset();
    @(posedge clock);
    rst_b <= 1'b1;
    t_update();
    t_b2b();
    t_mid_reset();
    test_done();
  end
endmodule
